// file: gac_top.sv
`timescale 1ns/1ps
module gac_top
  import gac_pkg::*;
(
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rstn_i,
  // ahb-lite slave
  input  wire logic                       hsel_i,
  input  wire logic [31:0]                haddr_i,
  input  wire logic [1:0]                 htrans_i,
  input  wire logic                       hwrite_i,
  input  wire logic [2:0]                 hsize_i,
  input  wire logic [31:0]                hwdata_i,
  input  wire logic                       hready_i,
  output logic      [31:0]                hrdata_o,
  output logic                            hreadyout_o,
  output logic                            hresp_o,
  // analogue converter core
  input  wire logic                       core_done_i,
  input  wire logic [9:0]                 core_result_i,
  output logic                            core_enable_o,
  output logic                            core_start_o,
  output logic                            core_sign_o,
  output logic                            core_single_ended_o,
  output logic                            core_midscale_o,
  output logic [gac_pkg::GAC_NUM_SOURCES-1:0] core_source_o,
  output logic                            core_diff_pair_o,
  output logic                            regulator_on_o,
  output logic                            regulator_force_zero_o,
  // interrupt controller
  output logic                            irq_o
);

  import gac_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] ctrl;
  logic        start_bit;
  logic        done_flag;
  logic        wr_pend;
  logic        rd_pend;
  logic [7:0]  idx_q;
  logic [9:0]  result;
  logic        seq_finish;
  logic        seq_busy;
  logic [9:0]  seq_result;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire ap_valid   = hsel_i & htrans_i[1] & hready_i;
  wire ap_write   = ap_valid & hwrite_i & (hsize_i == GAC_HSIZE_WORD);
  wire ap_read    = ap_valid & ~hwrite_i;

  wire hit_ctrl   = (idx_q == GAC_IDX_CTRL);
  wire hit_clear  = (idx_q == GAC_IDX_CLEAR);
  wire hit_result = (idx_q == GAC_IDX_RESULT);
  wire hit_status = (idx_q == GAC_IDX_STATUS);
  wire hit_mask   = (idx_q == GAC_IDX_MASK);

  wire we_ctrl    = wr_pend & hit_ctrl;
  wire we_clear   = wr_pend & hit_clear;
  wire we_status  = wr_pend & hit_status;
  wire we_mask    = wr_pend & hit_mask;

  // ----------------------------------------
  // control decisions
  // ----------------------------------------
  wire [3:0] chan = ctrl[GAC_SEL_HI:GAC_SEL_LO];

  // a start is only taken with the core enabled and idle
  wire go = we_ctrl & hwdata_i[GAC_BIT_START] & hwdata_i[GAC_BIT_EN]
          & ctrl[GAC_BIT_EN] & ~start_bit & ~seq_busy;

  wire done_clr = we_clear
                | (we_status & hwdata_i[GAC_BIT_STAT]);

  wire [15:0] ctrl_view = {ctrl[15:GAC_BIT_MINT], done_flag, ctrl[GAC_BIT_CLKSEL],
                           1'b0, start_bit, ctrl[GAC_BIT_EN]};

  wire [31:0] rd_mux = hit_ctrl   ? {16'h0000, ctrl_view} :
                       hit_result ? {22'h000000, result} :
                       hit_status ? {31'h00000000, done_flag} :
                       hit_mask   ? {31'h00000000, ctrl[GAC_BIT_MINT]} :
                       32'h0000_0000;

  // ----------------------------------------
  // input selection decode
  // ----------------------------------------
  logic [GAC_NUM_SOURCES-1:0] next_source;
  genvar g;
  generate
    for (g = 0; g < GAC_NUM_SOURCES; g = g + 1) begin : g_src
      // codes above the last source leave every select low
      assign next_source[g] = ctrl[GAC_BIT_SE] & (chan == 4'(g));
    end
  endgenerate

  wire next_diff_pair = ~ctrl[GAC_BIT_SE] & (chan != GAC_DIFF_PAIR01);

  // ----------------------------------------
  // bus phase tracking
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend     <= 1'b0;
      rd_pend     <= 1'b0;
      idx_q       <= 8'h00;
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h0000_0000;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend <= ap_write;
      rd_pend <= ap_read;
      if (ap_valid) begin
        idx_q <= haddr_i[9:2];
      end
      // one wait state on reads so a preceding write is seen
      hreadyout_o <= ~ap_read;
      if (rd_pend) begin
        hrdata_o <= rd_mux;
      end
      hresp_o <= 1'b0;
    end
  end

  // ----------------------------------------
  // control register
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl <= GAC_CTRL_RESET;
    end else if (we_ctrl) begin
      ctrl <= hwdata_i[15:0] & GAC_CTRL_RW_MASK;
    end else if (we_mask) begin
      ctrl[GAC_BIT_MINT] <= hwdata_i[0];
    end
  end

  // ----------------------------------------
  // start bit and done flag
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      start_bit <= 1'b0;
      done_flag <= 1'b0;
    end else begin
      if (!ctrl[GAC_BIT_EN]) begin
        start_bit <= 1'b0;
      end else if (go) begin
        start_bit <= 1'b1;
      end else if (seq_finish) begin
        start_bit <= 1'b0;
      end
      // completion beats a clear in the same cycle
      if (seq_finish) begin
        done_flag <= 1'b1;
      end else if (done_clr) begin
        done_flag <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // core drive and interrupt
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      result                 <= GAC_RESULT_RESET;
      core_enable_o          <= 1'b0;
      core_single_ended_o    <= 1'b0;
      core_midscale_o        <= 1'b0;
      core_source_o          <= '0;
      core_diff_pair_o       <= 1'b0;
      regulator_on_o         <= 1'b0;
      regulator_force_zero_o <= 1'b0;
      irq_o                  <= 1'b0;
    end else begin
      if (seq_finish) begin
        result <= seq_result;
      end
      core_enable_o          <= ctrl[GAC_BIT_EN];
      core_single_ended_o    <= ctrl[GAC_BIT_SE];
      core_midscale_o        <= ctrl[GAC_BIT_MUTE];
      core_source_o          <= next_source;
      core_diff_pair_o       <= next_diff_pair;
      regulator_on_o         <= ctrl[GAC_BIT_REG_ON];
      regulator_force_zero_o <= ctrl[GAC_BIT_REG_ZERO];
      irq_o                  <= done_flag & ctrl[GAC_BIT_MINT];
    end
  end

  // ----------------------------------------
  // sample sequencer
  // ----------------------------------------
  gac_seq u_seq (
    .sys_clk_i     (sys_clk_i),
    .rstn_i        (rstn_i),
    .enable_i      (ctrl[GAC_BIT_EN]),
    .go_i          (go),
    .chop_i        (ctrl[GAC_BIT_CHOP]),
    .sign_i        (ctrl[GAC_BIT_SIGN]),
    .core_done_i   (core_done_i),
    .core_result_i (core_result_i),
    .core_start_o  (core_start_o),
    .core_sign_o   (core_sign_o),
    .finish_o      (seq_finish),
    .busy_o        (seq_busy),
    .result_o      (seq_result)
  );

endmodule

// file: gac_pkg.sv
package gac_pkg;

  // ----------------------------------------
  // register map (index, byte address = 4 * index)
  // ----------------------------------------
  localparam logic [31:0] GAC_BLOCK_BASE = 32'h5000_1500;
  localparam logic [7:0]  GAC_IDX_CTRL   = 8'h00;
  localparam logic [7:0]  GAC_IDX_CLEAR  = 8'h08;
  localparam logic [7:0]  GAC_IDX_RESULT = 8'h0a;
  localparam logic [7:0]  GAC_IDX_STATUS = 8'h10;
  localparam logic [7:0]  GAC_IDX_MASK   = 8'h11;

  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int GAC_BIT_REG_ZERO = 15;
  localparam int GAC_BIT_REG_ON   = 14;
  localparam int GAC_BIT_CHOP     = 13;
  localparam int GAC_BIT_MUTE     = 12;
  localparam int GAC_BIT_SE       = 11;
  localparam int GAC_BIT_SIGN     = 10;
  localparam int GAC_SEL_HI       = 9;
  localparam int GAC_SEL_LO       = 6;
  localparam int GAC_BIT_MINT     = 5;
  localparam int GAC_BIT_DONE     = 4;
  localparam int GAC_BIT_CLKSEL   = 3;
  localparam int GAC_BIT_START    = 1;
  localparam int GAC_BIT_EN       = 0;
  localparam int GAC_BIT_STAT     = 0;

  localparam logic [15:0] GAC_CTRL_RESET   = 16'h0000;
  localparam logic [15:0] GAC_CTRL_RW_MASK = 16'hffe9;
  localparam logic [9:0]  GAC_RESULT_RESET = 10'h000;
  localparam logic [2:0]  GAC_HSIZE_WORD   = 3'h2;

  // ----------------------------------------
  // input selection
  // ----------------------------------------
  localparam int          GAC_NUM_SOURCES = 10;
  localparam logic [3:0]  GAC_CH_LAST     = 4'h9;
  localparam logic [3:0]  GAC_DIFF_PAIR01 = 4'h0;

  typedef enum logic [1:0] {
    GAC_IDLE   = 2'b00,
    GAC_FIRST  = 2'b01,
    GAC_SECOND = 2'b11,
    GAC_FINISH = 2'b10
  } gac_state_e;

endpackage

// file: gac_seq.sv
`timescale 1ns/1ps
module gac_seq
  import gac_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // control
  input  wire logic       enable_i,
  input  wire logic       go_i,
  input  wire logic       chop_i,
  input  wire logic       sign_i,
  // analogue core
  input  wire logic       core_done_i,
  input  wire logic [9:0] core_result_i,
  output logic            core_start_o,
  output logic            core_sign_o,
  // completion
  output logic            finish_o,
  output logic            busy_o,
  output logic [9:0]      result_o
);

  gac_state_e state;
  logic [9:0] first_sample;
  wire  [10:0] pair_sum = {1'b0, first_sample} + {1'b0, core_result_i};

  assign busy_o = (state != GAC_IDLE);

  // ----------------------------------------
  // sample sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state        <= GAC_IDLE;
      core_start_o <= 1'b0;
      core_sign_o  <= 1'b0;
      finish_o     <= 1'b0;
      first_sample <= GAC_RESULT_RESET;
      result_o     <= GAC_RESULT_RESET;
    end else if (!enable_i) begin
      // core held in reset: abandon any sample in flight
      state        <= GAC_IDLE;
      core_start_o <= 1'b0;
      core_sign_o  <= sign_i;
      finish_o     <= 1'b0;
    end else begin
      core_start_o <= 1'b0;
      finish_o     <= 1'b0;
      unique case (state)
        GAC_IDLE: begin
          core_sign_o <= sign_i;
          if (go_i) begin
            core_start_o <= 1'b1;
            state        <= GAC_FIRST;
          end
        end
        GAC_FIRST: begin
          if (core_done_i) begin
            first_sample <= core_result_i;
            if (chop_i) begin
              // second sample taken with opposite sign
              core_sign_o  <= ~sign_i;
              core_start_o <= 1'b1;
              state        <= GAC_SECOND;
            end else begin
              result_o <= core_result_i;
              state    <= GAC_FINISH;
            end
          end
        end
        GAC_SECOND: begin
          if (core_done_i) begin
            // mean of both halves cancels the core offset
            result_o <= pair_sum[10:1];
            state    <= GAC_FINISH;
          end
        end
        GAC_FINISH: begin
          finish_o    <= 1'b1;
          core_sign_o <= sign_i;
          state       <= GAC_IDLE;
        end
      endcase
    end
  end

endmodule

// file: gac_top_monitor.sv
`timescale 1ns/1ps
module gac_top_monitor
  import gac_pkg::*;
(
  // clock and reset
  input wire logic                       sys_clk_i,
  input wire logic                       rstn_i,
  // bus
  input wire logic                       hsel_i,
  input wire logic [1:0]                 htrans_i,
  input wire logic                       hwrite_i,
  input wire logic                       hready_i,
  input wire logic                       hreadyout_o,
  // core
  input wire logic                       core_done_i,
  input wire logic                       core_enable_o,
  input wire logic                       core_start_o,
  input wire logic                       core_sign_o,
  input wire logic                       core_single_ended_o,
  input wire logic [GAC_NUM_SOURCES-1:0] core_source_o,
  input wire logic                       core_diff_pair_o
);
  // ----
  // checks
  // ----
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire take = hsel_i & htrans_i[1] & hready_i;
  AST_RD_WAIT: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read data phase lacks its wait state");
  AST_WR_NOWAIT: assert property (take && hwrite_i |=> hreadyout_o)
    else $error("write data phase stalled");
  AST_PULSE: assert property (core_start_o |=> !core_start_o)
    else $error("sample request longer than one cycle");
  AST_EN_START: assert property (core_start_o |-> core_enable_o)
    else $error("sample request while converter held in reset");
  // second chop request must flip polarity seen two cycles back
  AST_CHOP_SIGN: assert property (
    core_start_o && $past(core_done_i) |-> core_sign_o != $past(core_sign_o, 2))
    else $error("second sample kept its polarity");
  AST_DIFF_SRC: assert property (!core_single_ended_o |-> core_source_o == '0)
    else $error("single-ended source driven in differential mode");
  AST_SE_ONEHOT: assert property (core_single_ended_o |-> $onehot0(core_source_o))
    else $error("more than one source selected");
  AST_SE_PAIR: assert property (core_single_ended_o |-> !core_diff_pair_o)
    else $error("pair select set in single-ended mode");
endmodule

bind gac_top gac_top_monitor u_mon (
  .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
  .core_done_i(core_done_i), .core_enable_o(core_enable_o), .core_start_o(core_start_o),
  .core_sign_o(core_sign_o), .core_single_ended_o(core_single_ended_o),
  .core_source_o(core_source_o), .core_diff_pair_o(core_diff_pair_o)
);

// file: gac_core_model.sv
`timescale 1ns/1ps
module gac_core_model (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  // from control
  input  wire logic       enable_i,
  input  wire logic       start_i,
  input  wire logic       sign_i,
  // bench settings
  input  wire logic [3:0] lat_i,
  input  wire logic [9:0] smp_a_i,
  input  wire logic [9:0] smp_b_i,
  // to control
  output logic            done_o,
  output logic [9:0]      result_o
);
  // ----
  // sampling
  // ----
  logic       run;
  logic [3:0] cnt;
  // sign-corrected value, polarity picks which one
  wire  [9:0] smp = sign_i ? smp_b_i : smp_a_i;
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      run <= 1'b0;
      cnt <= 4'h0;
      done_o <= 1'b0;
      result_o <= 10'h000;
    end else begin
      done_o <= 1'b0;
      // only valid with done, so scramble it elsewhere
      result_o <= ~result_o;
      if (!enable_i) run <= 1'b0;
      else if (start_i) begin
        run <= 1'b1;
        cnt <= lat_i;
      end else if (run && cnt <= 4'h1) begin
        run <= 1'b0;
        done_o <= 1'b1;
        result_o <= smp;
      end else if (run) cnt <= cnt - 4'h1;
    end
  end
endmodule

// file: general_adc_control_tb.sv
`timescale 1ns/1ps
module general_adc_control_tb;
  import gac_pkg::*;
  // ----
  // signals
  // ----
  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic        hsel   = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [2:0]  hsize  = GAC_HSIZE_WORD;
  logic [31:0] haddr  = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic        hrdy, hresp, cdone, cen, cstart, csign, cse, cmid, cpair, ron, rzero, irq;
  logic [9:0]  cres, csrc;
  logic [9:0]  sa     = '0;
  logic [9:0]  sb     = '0;
  logic [3:0]  lat    = 4'h1;
  logic [31:0] seed   = 32'h4c5debda;
  logic [7:0]  regs [6] = '{GAC_IDX_CTRL, GAC_IDX_CLEAR, GAC_IDX_RESULT,
                            GAC_IDX_STATUS, GAC_IDX_MASK, 8'h05};
  int          fails = 0;
  int          n_checks = 0;
  int          nstart = 0;
  int          n, mctrl, mres;

  always #20 clk = ~clk;
  always @(posedge clk) if (cstart === 1'b1) nstart <= nstart + 1;

  gac_top dut (
    .sys_clk_i(clk), .rstn_i(rstn), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
    .hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(hresp), .core_done_i(cdone),
    .core_result_i(cres), .core_enable_o(cen), .core_start_o(cstart), .core_sign_o(csign),
    .core_single_ended_o(cse), .core_midscale_o(cmid), .core_source_o(csrc),
    .core_diff_pair_o(cpair), .regulator_on_o(ron), .regulator_force_zero_o(rzero),
    .irq_o(irq));
  gac_core_model u_core (
    .sys_clk_i(clk), .rstn_i(rstn), .enable_i(cen), .start_i(cstart), .sign_i(csign),
    .lat_i(lat), .smp_a_i(sa), .smp_b_i(sb), .done_o(cdone), .result_o(cres));

  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // master waits for the slave, however long it stalls
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    xfer(1'b1, idx, wd);
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    check(rd, exp);
    check(hresp, 32'h0);
  endtask
  task automatic pins();
    logic [3:0] ch;
    ch = mctrl[9:6];
    check({cen, cse, cmid, ron, rzero, cpair, csrc}, {mctrl[0], mctrl[11], mctrl[12],
          mctrl[14], mctrl[15], ~mctrl[11] & (ch != 4'h0),
          (mctrl[11] && ch <= 4'h9) ? 10'h1 << ch : 10'h0});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----
  // sequence
  // ----
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    mctrl = 0;
    for (int i = 0; i < 6; i++) rdchk(regs[i], 32'h0);
    pins();
    // reserved codes written on purpose, they must select no single-ended source
    for (int i = 0; i < 32; i++) begin
      seed = lfsr(seed);
      mctrl = {seed[15:12], i[4], seed[10], i[3:0], seed[5], 1'b0, seed[3], 3'h0};
      wr(GAC_IDX_CTRL, {seed[31:16], mctrl[15:0]});
      rdchk(GAC_IDX_CTRL, mctrl);
      pins();
    end
    wr(GAC_IDX_CTRL, 32'h1);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      lat <= seed[3:0] | 4'h1;
      sa <= seed[13:4];
      sb <= seed[23:14];
      mctrl = {2'b00, i[0], i[1], 1'b1, i[2], 4'h2, seed[28], 5'h01};
      n = nstart;
      wr(GAC_IDX_CTRL, mctrl);
      wr(GAC_IDX_CTRL, mctrl | 2);
      do xfer(1'b0, GAC_IDX_STATUS, 32'h0); while (rd[0] !== 1'b1);
      check(nstart - n, i[0] ? 2 : 1);
      mres = i[0] ? (sa + sb) / 2 : (i[2] ? sb : sa);
      rdchk(GAC_IDX_RESULT, mres);
      rdchk(GAC_IDX_CTRL, mctrl | 16);
      check(irq, mctrl[5]);
      wr(GAC_IDX_MASK, 32'h1);
      rdchk(GAC_IDX_CTRL, mctrl | 48);
      check(irq, 1);
      if (i[1]) wr(GAC_IDX_CLEAR, seed);
      else wr(GAC_IDX_STATUS, 32'h1);
      rdchk(GAC_IDX_STATUS, 32'h0);
      check(irq, 0);
    end
    // slow sample, then pull enable mid-conversion
    lat <= 4'hf;
    n = nstart;
    wr(GAC_IDX_CTRL, 32'h3);
    wr(GAC_IDX_CTRL, 32'h0);
    repeat (20) @(posedge clk);
    mctrl = 0;
    rdchk(GAC_IDX_CTRL, 32'h0);
    rdchk(GAC_IDX_STATUS, 32'h0);
    pins();
    wr(GAC_IDX_CTRL, 32'h3);
    wr(8'h05, 32'hffffffff);
    rdchk(8'h05, 32'h0);
    // byte writes are dropped, control must keep its value
    hsize <= 3'h0;
    wr(GAC_IDX_CTRL, 32'h0000_0800);
    hsize <= GAC_HSIZE_WORD;
    rdchk(GAC_IDX_CTRL, 32'h1);
    check(nstart - n, 1);
    summarize();
  end

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    summarize();
  end
endmodule
